// ==== scc_regs.vh ====
// Register map, field positions, reset values and decode tables for the
// sensor channel configuration bank. Included by every design file.
`ifndef SCC_REGS_VH
`define SCC_REGS_VH

// Byte addresses on the host register port
`define SCC_ADDR_CH0_CHARGE 8'h49
`define SCC_ADDR_CH1_CHARGE 8'h4A
`define SCC_ADDR_CH2_CHARGE 8'h4B
`define SCC_ADDR_UI_FILTER 8'h50
`define SCC_ADDR_CH1_AUTO 8'h51

// Reset values
`define SCC_RST_CHARGE 8'h06
`define SCC_RST_UI_FILTER 8'h00
`define SCC_RST_CH1_AUTO 8'h01

// Charge options fields
`define SCC_UPLEN_HI 7
`define SCC_UPLEN_LO 6
`define SCC_CSDIV_BIT 5
`define SCC_UP_OVERRIDE_BIT 3
// Writable bits in inductive mode: only the divider
`define SCC_IND_WMASK 8'h20

// UI and filter fields
`define SCC_UI_HI 7
`define SCC_UI_LO 6
`define SCC_TWO_SIDED_BIT 5
`define SCC_ACF_BYP_BIT 4
`define SCC_LTA_HI 3
`define SCC_LTA_LO 2
`define SCC_ACF_HI 1
`define SCC_ACF_LO 0

// Channel 1 auto and debounce fields
`define SCC_CH1_MAN_BIT 7
`define SCC_FDB_OFF_BIT 4

// Sensor mode codes
`define SCC_MODE_CAP 2'b00
`define SCC_MODE_IND 2'b10

// Decode constants
`define SCC_UPLEN_DEFAULT 4'h0
`define SCC_LONG_BETA_BASE 4'h7
`define SCC_AC_BETA_BASE 3'h1
`define SCC_CS_DIV_FACTOR 3'h5

`endif

// ==== scc_charge_decode.v ====
// Charge options decode for one channel: up-length code and divider.
// Assumes the register value and mode come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.vh"

module scc_charge_decode (
  input wire [7:0] cfg,
  input wire [1:0] mode,
  output wire [3:0] up_length,
  output wire up_length_active,
  output wire [2:0] cs_div_factor
);

  // ----------------------------------------------------------------
  // Up-length decode
  // ----------------------------------------------------------------
  wire is_cap;
  assign is_cap = (mode == `SCC_MODE_CAP);
  // Field only applies in capacitive mode with the enable set
  assign up_length_active = is_cap & cfg[`SCC_UP_OVERRIDE_BIT]; // R3 R17
  // Codes 00..11 map to 0010,0110,1010,1110
  assign up_length = up_length_active ?
    {cfg[`SCC_UPLEN_HI:`SCC_UPLEN_LO], 2'b10} : `SCC_UPLEN_DEFAULT; // R2
  // Divider applies in both modes; factor 1 keeps normal size
  assign cs_div_factor = cfg[`SCC_CSDIV_BIT] ? `SCC_CS_DIV_FACTOR : 3'h1; // R4

endmodule // scc_charge_decode
`default_nettype wire

// ==== scc_ui_decode.v ====
// Decode of the shared UI/filter register and channel 1 control.
// Pure combinational; ui_cfg and auto_cfg are registered in the parent, mode is not.
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.vh"

module scc_ui_decode (
  input wire [7:0] ui_cfg,
  input wire [7:0] auto_cfg,
  input wire [1:0] mode,
  output reg [3:0] ui_mode,
  output wire sar_active,
  output wire [3:0] long_average_beta,
  output wire [2:0] ac_filter_beta,
  output wire channel1_auto
);

  // ----------------------------------------------------------------
  // UI selection: bit 3 marks the inductive table, code in bits 1-0
  // ----------------------------------------------------------------
  // Encoding: {inductive, code}; consumers look up the meaning
  always @* begin
    case (mode)
      `SCC_MODE_IND: ui_mode = {2'b10, ui_cfg[`SCC_UI_HI:`SCC_UI_LO]}; // R6 R15
      default: ui_mode = {2'b00, ui_cfg[`SCC_UI_HI:`SCC_UI_LO]}; // R5 R15
    endcase
  end

  // Capacitive codes 01..11 and inductive codes 10..11 run a SAR UI
  assign sar_active = (mode == `SCC_MODE_IND) ? ui_cfg[`SCC_UI_HI] :
    (ui_cfg[`SCC_UI_HI:`SCC_UI_LO] != 2'b00);
  assign long_average_beta = `SCC_LONG_BETA_BASE +
    {2'b00, ui_cfg[`SCC_LTA_HI:`SCC_LTA_LO]}; // R9
  assign ac_filter_beta = `SCC_AC_BETA_BASE +
    {1'b0, ui_cfg[`SCC_ACF_HI:`SCC_ACF_LO]}; // R10
  // Automatic channel 1 control only while a SAR UI runs
  assign channel1_auto = sar_active & ~auto_cfg[`SCC_CH1_MAN_BIT]; // R11 R12

endmodule // scc_ui_decode
`default_nettype wire

// ==== scc_config_regs.v ====
// Sensor channel configuration register bank: three per-channel charge
// option registers, the shared UI/filter register and channel 1 control.
// Assumes the I2C engine delivers byte-wide register strobes on clk.
// Summary of operation
// R1: Three charge option registers at 0x49-0x4B.
// R2: Up-length field maps to four charge codes.
// R3: Up-length applies only when enable bit set.
// R4: Divider bit shrinks sense capacitor fivefold.
// R5: Capacitive UI field selects four UIs.
// R6: Inductive UI field selects four UIs.
// R7: Bit 5 enables two-sided detection.
// R8: Bit 4 bypasses the AC filter.
// R9: Long average beta codes give 7-10.
// R10: AC filter beta codes give 1-4.
// R11: Manual bit clear: channel 1 automatic while a SAR UI runs.
// R12: Manual bit set: host controls channel 1.
// R13: Bit 4 set turns fast debounce off.
// R14: Reset values 0x06, 0x00, 0x01.
// R15: Sensor mode selects capacitive or inductive layout.
// R16: Internal-use bits are kept as written.
// R17: Inductive mode: only divider bit writable.
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.vh"

module scc_config_regs (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  output reg reg_rvalid_q,
  input wire [1:0] ch0_sensor_mode,
  input wire [1:0] ch1_sensor_mode,
  input wire [1:0] ch2_sensor_mode,
  output reg [11:0] up_length_q,
  output reg [2:0] up_length_active_q,
  output reg [8:0] cs_div_factor_q,
  output reg [3:0] ui_mode_q,
  output reg two_sided_en_q,
  output reg ac_filter_bypass_q,
  output reg [3:0] long_average_beta_q,
  output reg [2:0] ac_filter_beta_q,
  output reg channel1_auto_q,
  output reg channel1_manual_ctrl_q,
  output reg fast_debounce_active_q
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Each channel keeps its own byte; this bus only gathers them for reads
  wire [23:0] charge_bus;
  reg [7:0] ui_cfg_q;
  reg [7:0] auto_cfg_q;
  wire [5:0] mode_bus;
  assign mode_bus = {ch2_sensor_mode, ch1_sensor_mode, ch0_sensor_mode};

  // Channel 0 mode picks the layout of the shared registers
  wire [1:0] shared_mode;
  assign shared_mode = ch0_sensor_mode; // R15

  // ----------------------------------------------------------------
  // Per-channel charge option registers and decoders
  // ----------------------------------------------------------------
  wire [11:0] up_length_d;
  wire [2:0] up_length_active_d;
  wire [8:0] cs_div_factor_d;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
      wire [1:0] mode;
      wire [7:0] chan_addr;
      wire hit;
      wire [7:0] wmask;
      reg [7:0] charge_q;
      assign mode = mode_bus[2*gi+1:2*gi];
      // Address picked from the map, so no wide arithmetic is cut down
      assign chan_addr = (gi == 0) ? `SCC_ADDR_CH0_CHARGE :
        (gi == 1) ? `SCC_ADDR_CH1_CHARGE : `SCC_ADDR_CH2_CHARGE;
      assign hit = reg_wr && (reg_addr == chan_addr); // R1
      // Inductive layout freezes every bit but the divider; internal-use
      // bits otherwise keep whatever the host wrote
      assign wmask = (mode == `SCC_MODE_IND) ? `SCC_IND_WMASK : 8'hFF; // R17 R16
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          charge_q <= `SCC_RST_CHARGE; // R14
        end else if (hit) begin
          charge_q <= (reg_wdata & wmask) | (charge_q & ~wmask);
        end
      end
      assign charge_bus[8*gi+7:8*gi] = charge_q;
      scc_charge_decode u_dec (
        .cfg(charge_q),
        .mode(mode),
        .up_length(up_length_d[4*gi+3:4*gi]),
        .up_length_active(up_length_active_d[gi]),
        .cs_div_factor(cs_div_factor_d[3*gi+2:3*gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Shared registers
  // ----------------------------------------------------------------
  // Whole byte kept, so internal-use bits read back as written
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ui_cfg_q <= `SCC_RST_UI_FILTER; // R14
      auto_cfg_q <= `SCC_RST_CH1_AUTO; // R14
    end else if (reg_wr) begin
      if (reg_addr == `SCC_ADDR_UI_FILTER) begin
        ui_cfg_q <= reg_wdata;
      end
      if (reg_addr == `SCC_ADDR_CH1_AUTO) begin
        auto_cfg_q <= reg_wdata; // R16
      end
    end
  end

  wire [3:0] ui_mode_d;
  wire [3:0] long_average_beta_d;
  wire [2:0] ac_filter_beta_d;
  wire channel1_auto_d;

  scc_ui_decode u_ui (
    .ui_cfg(ui_cfg_q),
    .auto_cfg(auto_cfg_q),
    .mode(shared_mode),
    .ui_mode(ui_mode_d),
    .sar_active(),
    .long_average_beta(long_average_beta_d),
    .ac_filter_beta(ac_filter_beta_d),
    .channel1_auto(channel1_auto_d)
  );

  // ----------------------------------------------------------------
  // Registered control outputs
  // ----------------------------------------------------------------
  // One cycle of latency after a write; outputs stay glitch free
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_length_q <= 12'h000;
      up_length_active_q <= 3'h0;
      cs_div_factor_q <= 9'h049;
      ui_mode_q <= 4'h0;
      two_sided_en_q <= 1'b0;
      ac_filter_bypass_q <= 1'b0;
      long_average_beta_q <= 4'h7;
      ac_filter_beta_q <= 3'h1;
      channel1_auto_q <= 1'b0;
      channel1_manual_ctrl_q <= 1'b0;
      fast_debounce_active_q <= 1'b1;
    end else begin
      up_length_q <= up_length_d; // R2 R3
      up_length_active_q <= up_length_active_d; // R3
      cs_div_factor_q <= cs_div_factor_d; // R4
      ui_mode_q <= ui_mode_d; // R5 R6
      two_sided_en_q <= ui_cfg_q[`SCC_TWO_SIDED_BIT]; // R7
      ac_filter_bypass_q <= ui_cfg_q[`SCC_ACF_BYP_BIT]; // R8
      long_average_beta_q <= long_average_beta_d; // R9
      ac_filter_beta_q <= ac_filter_beta_d; // R10
      channel1_auto_q <= channel1_auto_d; // R11
      channel1_manual_ctrl_q <= auto_cfg_q[`SCC_CH1_MAN_BIT]; // R12
      fast_debounce_active_q <= ~auto_cfg_q[`SCC_FDB_OFF_BIT]; // R13
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero rather than stalling the host
  reg [7:0] rdata_d;
  always @* begin
    case (reg_addr)
      `SCC_ADDR_CH0_CHARGE: rdata_d = charge_bus[7:0];
      `SCC_ADDR_CH1_CHARGE: rdata_d = charge_bus[15:8];
      `SCC_ADDR_CH2_CHARGE: rdata_d = charge_bus[23:16];
      `SCC_ADDR_UI_FILTER: rdata_d = ui_cfg_q;
      `SCC_ADDR_CH1_AUTO: rdata_d = auto_cfg_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

endmodule // scc_config_regs
`default_nettype wire

// ==== scc_host.sv ====
// Host model: single-byte register writes and reads on the strobe port.
// Assumes the bank samples strobes and address on the rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module scc_host (
  input wire logic clk,
  input wire logic reg_rvalid_q,
  input wire logic [7:0] reg_rdata_q,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // -----------
  // Bus cycles
  // -----------
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0_0000;
  // Idle lines show inverted stale values so the bank cannot lean on them
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    q = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 8'hxx;
  endtask
endmodule // scc_host
`default_nettype wire

// ==== scc_config_regs_chk.sv ====
// Checker for the configuration bank, bound to every instance.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module scc_config_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rvalid_q,
  input wire logic [1:0] ch0_sensor_mode,
  input wire logic [11:0] up_length_q,
  input wire logic [2:0] up_length_active_q,
  input wire logic [8:0] cs_div_factor_q,
  input wire logic [3:0] ui_mode_q,
  input wire logic two_sided_en_q,
  input wire logic ac_filter_bypass_q,
  input wire logic [3:0] long_average_beta_q,
  input wire logic [2:0] ac_filter_beta_q,
  input wire logic channel1_auto_q,
  input wire logic channel1_manual_ctrl_q,
  input wire logic fast_debounce_active_q
);
  // -----------
  // Properties
  // -----------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A write not overtaken by another to the same place; decode lands two edges on
  sequence s_wr(a);
    reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
  endsequence
  a_rd_answer: assert property (reg_rd |=> reg_rvalid_q)
    else $error("read strobe not answered");
  a_rvalid_cause: assert property (reg_rvalid_q |-> $past(reg_rd))
    else $error("read valid without read");
  a_long_beta: assert property (s_wr(8'h50) |=>
    long_average_beta_q == 4'h7 + $past(reg_wdata[3:2], 2))
    else $error("long average beta wrong");
  a_ac_beta: assert property (s_wr(8'h50) |=>
    ac_filter_beta_q == 3'h1 + $past(reg_wdata[1:0], 2))
    else $error("ac filter beta wrong");
  a_filter_bits: assert property (s_wr(8'h50) |=>
    {two_sided_en_q, ac_filter_bypass_q} == $past(reg_wdata[5:4], 2))
    else $error("two-sided or bypass wrong");
  a_ch1_fields: assert property (s_wr(8'h51) |=>
    {channel1_manual_ctrl_q, fast_debounce_active_q} ==
    {$past(reg_wdata[7], 2), !$past(reg_wdata[4], 2)})
    else $error("channel 1 control or debounce wrong");
  a_auto_cause: assert property (channel1_auto_q |-> !channel1_manual_ctrl_q &&
    (ui_mode_q[3] ? ui_mode_q[1] : ui_mode_q[1:0] != 2'b00))
    else $error("channel 1 auto without sar ui");
  a_div_factor: assert property (s_wr(8'h49) |=>
    cs_div_factor_q[2:0] == ($past(reg_wdata[5], 2) ? 3'h5 : 3'h1))
    else $error("divider factor wrong");
  a_uplen_code: assert property (
    (reg_wr && reg_addr == 8'h49 && ch0_sensor_mode == 2'b00) ##1
    (ch0_sensor_mode == 2'b00 && !(reg_wr && reg_addr == 8'h49)) |=>
    up_length_q[3:0] == ($past(reg_wdata[3], 2) ? {$past(reg_wdata[7:6], 2), 2'b10} : 4'h0))
    else $error("up length code wrong");
  a_ind_no_uplen: assert property (ch0_sensor_mode == 2'b10 |=>
    up_length_q[3:0] == 4'h0 && !up_length_active_q[0])
    else $error("up length active in inductive mode");
  // Main scenarios
  c_ui_write: cover property (s_wr(8'h50));
  c_auto: cover property (channel1_auto_q);
  c_unmapped: cover property (reg_rd && reg_addr == 8'h4C);
endmodule // scc_config_regs_chk
bind scc_config_regs scc_config_regs_chk i_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rvalid_q, .ch0_sensor_mode, .up_length_q, .up_length_active_q, .cs_div_factor_q,
  .ui_mode_q, .two_sided_en_q, .ac_filter_bypass_q, .long_average_beta_q, .ac_filter_beta_q,
  .channel1_auto_q, .channel1_manual_ctrl_q, .fast_debounce_active_q);
`default_nettype wire

// ==== test_scc_config_regs.sv ====
// Self-checking bench for the configuration bank driven by the host model.
// Assumes inputs change 1 ns after the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module test_scc_config_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, q, d, e, c;
  logic reg_wr, reg_rd, reg_rvalid_q, two_sided_en_q, ac_filter_bypass_q;
  logic channel1_auto_q, channel1_manual_ctrl_q, fast_debounce_active_q;
  logic [11:0] up_length_q;
  logic [2:0] up_length_active_q, ac_filter_beta_q;
  logic [8:0] cs_div_factor_q;
  logic [3:0] ui_mode_q, long_average_beta_q;
  logic [7:0] chg [3] = '{8'h06, 8'h06, 8'h06};
  logic [1:0] md [3] = '{2'b00, 2'b00, 2'b00};
  int failures = 0, n_tests = 0, cyc = 0, seed = 56544, k;
  wire [1:0] ch0_sensor_mode = md[0];
  wire [1:0] ch1_sensor_mode = md[1];
  wire [1:0] ch2_sensor_mode = md[2];
  // ---------------------
  // Clock, parts, timeout
  // ---------------------
  always #5 clk = ~clk;
  scc_config_regs i_scc_config_regs (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .reg_rvalid_q, .ch0_sensor_mode, .ch1_sensor_mode, .ch2_sensor_mode,
    .up_length_q, .up_length_active_q, .cs_div_factor_q, .ui_mode_q, .two_sided_en_q,
    .ac_filter_bypass_q, .long_average_beta_q, .ac_filter_beta_q, .channel1_auto_q,
    .channel1_manual_ctrl_q, .fast_debounce_active_q);
  scc_host i_scc_host (.clk, .reg_rvalid_q, .reg_rdata_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  // About 1700 cycles are needed; a hang stops well past that
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      close_out();
    end
  end
  // --------------------
  // Helpers and models
  // --------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_scc_host.xfer(1'b1, a, v, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    i_scc_host.xfer(1'b0, a, 8'h00, q);
    chk(q, x);
  endtask
  // Up-length is only in force in capacitive layout with its enable bit
  function automatic logic [3:0] f_up(input logic [7:0] r, input logic [1:0] m);
    return (m == 2'b00 && r[3]) ? {r[7:6], 2'b10} : 4'h0;
  endfunction
  function automatic logic f_auto(input logic [7:0] u, input logic [7:0] a, input logic [1:0] m);
    return !a[7] && (m == 2'b10 ? u[7] : u[7:6] != 2'b00);
  endfunction
  // ---------
  // Sequence
  // ---------
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    for (k = 0; k < 3; k++) rd(8'h49 + 8'(k), 8'h06);
    rd(8'h50, 8'h00);
    rd(8'h51, 8'h01);
    rd(8'h4C, 8'h00);
    chk(cs_div_factor_q, 9'h049);
    chk({long_average_beta_q, ac_filter_beta_q, fast_debounce_active_q}, 8'h73);
    // Random modes and data, all-ones corners first; a stray write hits a hole
    for (int i = 0; i < 120; i++) begin
      for (k = 0; k < 3; k++) md[k] = {1'($random(seed)), 1'b0};
      d = (i == 0) ? 8'hFF : 8'($random(seed));
      e = 8'($random(seed));
      c = (i < 3) ? 8'hFF : 8'($random(seed));
      k = i % 3;
      wr(8'h50, d);
      wr(8'h51, e);
      wr(8'h4F, ~d);
      wr(8'h49 + 8'(k), c);
      chg[k] = (md[k] == 2'b10) ? ((chg[k] & 8'hDF) | (c & 8'h20)) : c;
      rd(8'h50, d);
      rd(8'h51, e);
      rd(8'h49 + 8'(k), chg[k]);
      for (k = 0; k < 3; k++) begin
        chk(up_length_q[4*k +: 4], f_up(chg[k], md[k]));
        chk(up_length_active_q[k], md[k] == 2'b00 && chg[k][3]);
        chk(cs_div_factor_q[3*k +: 3], chg[k][5] ? 3'h5 : 3'h1);
      end
      chk(ui_mode_q, {md[0] == 2'b10, 1'b0, d[7:6]});
      chk({two_sided_en_q, ac_filter_bypass_q}, d[5:4]);
      chk(long_average_beta_q, 4'h7 + d[3:2]);
      chk(ac_filter_beta_q, 3'h1 + d[1:0]);
      chk({channel1_manual_ctrl_q, fast_debounce_active_q}, {e[7], !e[4]});
      chk(channel1_auto_q, f_auto(d, e, md[0]));
    end
    close_out();
  end
endmodule // test_scc_config_regs
`default_nettype wire
